// File: hmc_halt_mode_controller.sv
// Top: halt mode controller for the two deepest low-power states
//
// Behaviour
// - Deep low-power states are entered only by the CPU halt instruction.
// - Oscillator interrupt enable 0 selects full halt, 1 selects timebase-retaining halt.
// - Timebase halt wakes on timebase or clock security interrupt, wake-capable interrupt or reset only.
// - Leaving timebase halt by reset or interrupt inserts 4096 cycle delay.
// - After the delay the CPU services the waking interrupt or fetches reset vector.
// - Entering timebase halt clears interrupt mask; pending interrupt wakes at once.
// - In timebase halt only oscillator and timebase counter stay clocked.
// - With oscillator interrupt enabled, watchdog causes no reset on timebase halt entry.
// - Full halt wakes only on wake-capable interrupt or reset, not timebase.
// - Full halt exit restarts oscillator at once then holds CPU 4096 cycles.
// - Entering full halt forces interrupt mask to 0; pending interrupt wakes at once.
// - Full halt stops oscillator, processing and peripheral clocks.
// - Watchdog-halt option decides if halt with watchdog on gives watchdog reset.
// - Servicing wake interrupt pushes condition codes and sets mask until popped.
// - External lines wake either halt; timebase or clock security only timebase halt.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module hmc_halt_mode_controller
  import hmc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        halt_exec,
  input  wire logic        watchdog_active,
  input  wire logic        wake_reset,
  input  wire logic [3:0]  ext_irq,
  input  wire logic        timebase_irq,
  input  wire logic        clock_security_irq,
  input  wire logic        iret_pop,
  output logic             cpu_hold,
  output logic             cpu_resume_irq,
  output logic             cpu_resume_reset,
  output logic             int_mask,
  output logic             ccr_push,
  output logic             osc_enable,
  output logic             timebase_clk_en,
  output logic             periph_clk_en,
  output logic             watchdog_reset
);
  hmc_cfg_if  cfg ();
  hmc_state_e state;
  logic       ext_wake;
  logic       tb_wake;
  logic       wake_by_reset;
  logic       load;
  logic       busy;
  logic       expire;
  logic       wdg_trip;
  logic [31:0] status_word;
  logic [31:0] prdata_c;
  logic        pslverr_c;

  assign ext_wake = |ext_irq;
  assign tb_wake  = timebase_irq || clock_security_irq;
  // Halt with watchdog running, option set and oscillator interrupt disabled resets instead of halting
  assign wdg_trip = halt_exec && watchdog_active && cfg.watchdog_halt_option
                    && !cfg.osc_int_enable;
  assign load = (state == HMC_ACTIVE_HALT && (ext_wake || tb_wake || wake_reset))
             || (state == HMC_FULL_HALT && (ext_wake || wake_reset));

  assign status_word = {26'h0000000, wake_by_reset, busy, state, cfg.osc_int_enable};

  hmc_apb_regs u_regs (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .status_word (status_word),
    .prdata      (prdata_c),
    .pslverr     (pslverr_c),
    .cfg         (cfg.regs)
  );

  hmc_startup_timer u_timer (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .load    (load),
    .busy    (busy),
    .expire  (expire)
  );

  // Registered APB answer: one wait state gives flip-flop outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= HMC_WORD_ZERO;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= prdata_c;
      pslverr <= pslverr_c && !pready;
    end
  end

  // Mode sequencing
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= HMC_RUN;
    end else begin
      unique case (state)
        HMC_RUN: begin
          if (halt_exec && !wdg_trip) begin
            state <= cfg.osc_int_enable ? HMC_ACTIVE_HALT : HMC_FULL_HALT;
          end
        end
        HMC_ACTIVE_HALT: begin
          if (ext_wake || tb_wake || wake_reset) begin
            state <= HMC_STARTUP;
          end
        end
        HMC_FULL_HALT: begin
          if (ext_wake || wake_reset) begin
            state <= HMC_STARTUP;
          end
        end
        HMC_STARTUP: begin
          if (expire) begin
            state <= HMC_RUN;
          end
        end
        default: state <= HMC_RUN;
      endcase
    end
  end

  // Remembers whether the wake came from reset, to pick the resume path
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wake_by_reset <= 1'b0;
    end else if (load) begin
      wake_by_reset <= wake_reset;
    end
  end

  // Resume pulses and condition code push
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cpu_resume_irq   <= 1'b0;
      cpu_resume_reset <= 1'b0;
      ccr_push         <= 1'b0;
    end else begin
      cpu_resume_irq   <= (state == HMC_STARTUP) && expire && !wake_by_reset;
      cpu_resume_reset <= (state == HMC_STARTUP) && expire && wake_by_reset;
      ccr_push         <= (state == HMC_STARTUP) && expire && !wake_by_reset;
    end
  end

  // Interrupt mask: cleared on halt entry, set while the wake routine runs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      int_mask <= 1'b1;
    end else if (state == HMC_RUN && halt_exec && !wdg_trip) begin
      int_mask <= 1'b0;
    end else if (state == HMC_STARTUP && expire && !wake_by_reset) begin
      int_mask <= 1'b1;
    end else if (state == HMC_STARTUP && expire) begin
      int_mask <= 1'b1;
    end else if (iret_pop) begin
      int_mask <= 1'b0;
    end
  end

  // Clock gating; the CPU stays held until the counter expires
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cpu_hold        <= 1'b0;
      osc_enable      <= 1'b1;
      timebase_clk_en <= 1'b1;
      periph_clk_en   <= 1'b1;
      watchdog_reset  <= 1'b0;
    end else begin
      cpu_hold        <= (state != HMC_RUN) && !((state == HMC_STARTUP) && expire);
      osc_enable      <= !(state == HMC_FULL_HALT && !load);
      timebase_clk_en <= !(state == HMC_FULL_HALT);
      periph_clk_en   <= (state == HMC_RUN) || ((state == HMC_STARTUP) && expire);
      watchdog_reset  <= wdg_trip && state == HMC_RUN;
    end
  end
endmodule : hmc_halt_mode_controller
`default_nettype wire

// File: hmc_pkg.sv
// Package: states, register map and timing constants of the halt mode controller
package hmc_pkg;
  localparam int          HMC_STARTUP_CYCLES = 4096;
  localparam logic [12:0] HMC_CNT_LOAD       = 13'h1000;
  localparam logic [12:0] HMC_CNT_ZERO       = 13'h0000;
  localparam logic [12:0] HMC_CNT_ONE        = 13'h0001;
  localparam logic [11:0] HMC_ADDR_CTRL      = 12'h000;
  localparam logic [11:0] HMC_ADDR_STATUS    = 12'h004;
  localparam logic [31:0] HMC_WORD_ZERO      = 32'h0000_0000;
  localparam int          HMC_BIT_OIE        = 0;
  localparam int          HMC_BIT_WDG_OPT    = 1;
  localparam logic        HMC_RST_OIE        = 1'b0;
  localparam logic        HMC_RST_WDG_OPT    = 1'b0;
  typedef enum logic [2:0] {
    HMC_RUN,
    HMC_ACTIVE_HALT,
    HMC_FULL_HALT,
    HMC_STARTUP
  } hmc_state_e;
endpackage : hmc_pkg

// File: hmc_cfg_if.sv
// Interface: configuration bits passing from the register slave to the controller
`timescale 1ns/1ps
`default_nettype none
interface hmc_cfg_if;
  logic osc_int_enable;
  logic watchdog_halt_option;
  modport regs (output osc_int_enable, output watchdog_halt_option);
  modport ctrl (input osc_int_enable, input watchdog_halt_option);
endinterface : hmc_cfg_if
`default_nettype wire

// File: hmc_apb_regs.sv
// APB slave holding the configuration register and reading back the status word
`timescale 1ns/1ps
`default_nettype none
module hmc_apb_regs
  import hmc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] status_word,
  output logic      [31:0] prdata,
  output logic             pslverr,
  hmc_cfg_if.regs          cfg
);
  logic access;
  logic mapped;
  logic seen;
  assign access = psel && penable;

  // Mirrors the registered pready so a write lands only on the answering edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seen <= 1'b0;
    end else begin
      seen <= access && !seen;
    end
  end
  assign mapped = (paddr == HMC_ADDR_CTRL) || (paddr == HMC_ADDR_STATUS);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg.osc_int_enable       <= HMC_RST_OIE;
      cfg.watchdog_halt_option <= HMC_RST_WDG_OPT;
    end else if (access && seen && pwrite && paddr == HMC_ADDR_CTRL) begin
      cfg.osc_int_enable       <= pwdata[HMC_BIT_OIE];
      cfg.watchdog_halt_option <= pwdata[HMC_BIT_WDG_OPT];
    end
  end

  // Read data is combinational within the access cycle; the top registers it and answers with pready after one wait state
  always_comb begin
    prdata  = HMC_WORD_ZERO;
    pslverr = access && !mapped;
    if (paddr == HMC_ADDR_CTRL) begin
      prdata[HMC_BIT_OIE]     = cfg.osc_int_enable;
      prdata[HMC_BIT_WDG_OPT] = cfg.watchdog_halt_option;
    end else if (paddr == HMC_ADDR_STATUS) begin
      prdata = status_word;
    end
  end
endmodule : hmc_apb_regs
`default_nettype wire

// File: hmc_startup_timer.sv
// Start-up delay counter loaded on each halt exit
`timescale 1ns/1ps
`default_nettype none
module hmc_startup_timer
  import hmc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic load,
  output logic      busy,
  output logic      expire
);
  logic [12:0] count;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count <= HMC_CNT_ZERO;
    end else if (load) begin
      count <= HMC_CNT_LOAD;
    end else if (count != HMC_CNT_ZERO) begin
      count <= count - HMC_CNT_ONE;
    end
  end
  assign busy   = (count != HMC_CNT_ZERO);
  assign expire = (count == HMC_CNT_ONE);
endmodule : hmc_startup_timer
`default_nettype wire

// File: hmc_halt_mode_controller_asserts.sv
// Checker: timing relations at the halt mode controller ports
`timescale 1ns/1ps
`default_nettype none
module hmc_chk (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       halt_exec,
  input wire logic       watchdog_active,
  input wire logic       wake_reset,
  input wire logic [3:0] ext_irq,
  input wire logic       iret_pop,
  input wire logic       cpu_hold,
  input wire logic       cpu_resume_irq,
  input wire logic       cpu_resume_reset,
  input wire logic       int_mask,
  input wire logic       ccr_push,
  input wire logic       osc_enable,
  input wire logic       timebase_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       watchdog_reset
);
  logic [12:0] hold_len;
  // Saturates so a long halt cannot wrap back below the delay
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) hold_len <= 13'h0000;
    else if (!cpu_hold) hold_len <= 13'h0000;
    else if (hold_len != 13'h1fff) hold_len <= hold_len + 13'h0001;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  property p_enter; $rose(cpu_hold) |-> $past(halt_exec) || $past(halt_exec, 2); endproperty
  a_enter: assert property (p_enter) else $error("hold without halt");
  property p_mask; halt_exec && !cpu_hold && !watchdog_active |-> ##[1:2] !int_mask; endproperty
  a_mask: assert property (p_mask) else $error("mask not cleared");
  property p_gate; cpu_hold |-> !periph_clk_en; endproperty
  a_gate: assert property (p_gate) else $error("peripheral clock on");
  property p_full; !osc_enable |-> !timebase_clk_en && cpu_hold; endproperty
  a_full: assert property (p_full) else $error("clock on in full halt");
  property p_osc; !osc_enable && (ext_irq != 4'h0 || wake_reset) |-> ##[1:2] osc_enable; endproperty
  a_osc: assert property (p_osc) else $error("oscillator late");
  property p_delay; cpu_resume_irq || cpu_resume_reset |-> hold_len >= 13'h1000; endproperty
  a_delay: assert property (p_delay) else $error("delay short");
  property p_push; ccr_push == cpu_resume_irq; endproperty
  a_push: assert property (p_push) else $error("push mismatch");
  property p_setm; cpu_resume_irq |-> ##[0:1] int_mask; endproperty
  a_setm: assert property (p_setm) else $error("mask not set");
  property p_pop; iret_pop && !cpu_hold && !cpu_resume_irq |=> !int_mask; endproperty
  a_pop: assert property (p_pop) else $error("mask kept");
  property p_wdg; watchdog_reset |-> $past(halt_exec) && $past(watchdog_active); endproperty
  a_wdg: assert property (p_wdg) else $error("stray watchdog reset");
endmodule // hmc_chk
bind hmc_halt_mode_controller hmc_chk u_chk (.clk_sys, .rst_b, .halt_exec, .watchdog_active,
  .wake_reset, .ext_irq, .iret_pop, .cpu_hold, .cpu_resume_irq, .cpu_resume_reset, .int_mask,
  .ccr_push, .osc_enable, .timebase_clk_en, .periph_clk_en, .watchdog_reset);
`default_nettype wire

// File: hmc_cpu_model.sv
// Partner: CPU core and external wake sources
`timescale 1ns/1ps
`default_nettype none
module hmc_cpu_model (
  input  wire logic       clk_sys,
  input  wire logic       cpu_resume_irq,
  output var  logic       halt_exec,
  output var  logic [3:0] ext_irq,
  output var  logic       iret_pop
);
  int isr_left = 0;
  initial begin
    halt_exec = 1'b0;
    ext_irq = 4'h0;
    iret_pop = 1'b0;
  end
  task automatic halt();
    @(posedge clk_sys);
    halt_exec <= 1'b1;
    @(posedge clk_sys);
    halt_exec <= 1'b0;
  endtask
  task automatic raise(input logic [3:0] m);
    @(posedge clk_sys);
    ext_irq <= ext_irq | m;
  endtask
  // Latch drops at vector fetch; short routine then pops condition codes
  always @(posedge clk_sys) begin
    iret_pop <= 1'b0;
    if (cpu_resume_irq) begin
      ext_irq <= 4'h0;
      isr_left <= 8;
    end else if (isr_left == 1) begin
      isr_left <= 0;
      iret_pop <= 1'b1;
    end else if (isr_left > 0) isr_left <= isr_left - 1;
  end
endmodule // hmc_cpu_model
`default_nettype wire

// File: hmc_halt_mode_controller_bench.sv
// Testbench: register access, halt entry and wake-up of the halt mode controller
`timescale 1ns/1ps
`default_nettype none
module hmc_halt_mode_controller_bench;
  import hmc_pkg::*;
  logic        clk_sys, rst_b, psel, penable, pwrite, watchdog_active, wake_reset, err;
  logic        timebase_irq, clock_security_irq, pready, pslverr, halt_exec, iret_pop;
  logic        cpu_hold, cpu_resume_irq, cpu_resume_reset, int_mask, ccr_push;
  logic        osc_enable, timebase_clk_en, periph_clk_en, watchdog_reset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  ext_irq;
  int          n_fail = 0, checks = 0, cyc = 0, n;
  hmc_halt_mode_controller u_dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .halt_exec, .watchdog_active, .wake_reset, .ext_irq,
    .timebase_irq, .clock_security_irq, .iret_pop, .cpu_hold, .cpu_resume_irq,
    .cpu_resume_reset, .int_mask, .ccr_push, .osc_enable, .timebase_clk_en, .periph_clk_en,
    .watchdog_reset);
  hmc_cpu_model u_cpu (.clk_sys, .cpu_resume_irq, .halt_exec, .ext_irq, .iret_pop);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Five wake-ups of about 4100 cycles each fit well under this ceiling
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ticks(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic side(input logic tb, input logic clock_security_monitor);
    @(posedge clk_sys);
    timebase_irq <= tb;
    clock_security_irq <= clock_security_monitor;
  endtask
  // Counts edges until a resume pulse, then lets the routine return
  task automatic wake_chk();
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cpu_resume_irq !== 1'b1 && cpu_resume_reset !== 1'b1);
    cmp_cnt(n, HMC_STARTUP_CYCLES, HMC_STARTUP_CYCLES + 7);
    cmp(cpu_hold, 1'b0);
    ticks(12);
  endtask
  task automatic t_regs();
    ticks(10);
    cmp(cpu_hold, 1'b0);
    apb(1'b0, HMC_ADDR_CTRL, HMC_WORD_ZERO);
    cmp(rd, 32'h0000_0000);
    apb(1'b1, HMC_ADDR_CTRL, 32'h0000_0003);
    apb(1'b0, HMC_ADDR_CTRL, HMC_WORD_ZERO);
    cmp(rd, 32'h0000_0003);
    apb(1'b0, 12'h008, HMC_WORD_ZERO);
    cmp(rd, 32'h0000_0000);
    cmp(err, 1'b1);
  endtask
  task automatic t_full();
    apb(1'b1, HMC_ADDR_CTRL, 32'h0000_0000);
    u_cpu.halt();
    ticks(3);
    cmp({cpu_hold, int_mask, osc_enable, timebase_clk_en, periph_clk_en}, 5'h10);
    side(1'b1, 1'b1);
    ticks(20);
    cmp(cpu_hold, 1'b1);
    side(1'b0, 1'b0);
    u_cpu.raise(4'h2);
    wake_chk();
    cmp(int_mask, 1'b0);
  endtask
  task automatic t_active();
    apb(1'b1, HMC_ADDR_CTRL, 32'h0000_0001);
    u_cpu.halt();
    ticks(3);
    cmp({cpu_hold, int_mask, osc_enable, timebase_clk_en, periph_clk_en}, 5'h16);
    side(1'b0, 1'b1);
    wake_chk();
    side(1'b0, 1'b0);
    u_cpu.halt();
    ticks(3);
    @(posedge clk_sys);
    wake_reset <= 1'b1;
    @(posedge clk_sys);
    wake_reset <= 1'b0;
    #1;
    wait (cpu_resume_reset === 1'b1 || cpu_hold !== 1'b1 || cyc > 30000);
    cmp(cpu_resume_reset, 1'b1);
    #1;
    cmp(int_mask, 1'b1);
    ticks(12);
  endtask
  task automatic t_pend_wdg();
    apb(1'b1, HMC_ADDR_CTRL, 32'h0000_0000);
    u_cpu.raise(4'h1);
    u_cpu.halt();
    wake_chk();
    watchdog_active <= 1'b1;
    apb(1'b1, HMC_ADDR_CTRL, 32'h0000_0002);
    u_cpu.halt();
    #1;
    cmp({watchdog_reset, cpu_hold}, 2'h2);
    apb(1'b1, HMC_ADDR_CTRL, 32'h0000_0003);
    u_cpu.halt();
    #1;
    cmp(watchdog_reset, 1'b0);
    u_cpu.raise(4'h8);
    wake_chk();
  endtask
  initial begin
    {psel, penable, pwrite, watchdog_active, wake_reset} = 5'h00;
    {timebase_irq, clock_security_irq} = 2'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rst_b = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_full();
    t_active();
    t_pend_wdg();
    complete_run();
  end
endmodule // hmc_halt_mode_controller_bench
`default_nettype wire
